// File: rrx_pkg.sv
// package of opcodes, field positions, reset values and state types
// assumes a 14-bit instruction word and an 8-bit data path
package rrx_pkg;

  // ----------------------------------------------------------------
  // widths and field positions
  // ----------------------------------------------------------------
  localparam int INSTR_W    = 14;
  localparam int DATA_W     = 8;
  localparam int FADDR_W    = 7;
  localparam int PC_W       = 13;
  localparam int DEST_BIT   = 7;   // destination-select bit of a file op
  localparam int MSB_BIT    = 7;   // bit that leaves into the carry
  localparam int ENABLE_BIT = 7;   // global_interrupt_enable position

  // ----------------------------------------------------------------
  // opcode patterns and masks
  // ----------------------------------------------------------------
  localparam logic [13:0] NOP_MASK     = 14'h3F9F;
  localparam logic [13:0] NOP_CODE     = 14'h0000;
  localparam logic [13:0] INT_RET_MASK = 14'h3FFF;
  localparam logic [13:0] INT_RET_CODE = 14'h0009;
  localparam logic [13:0] LIT_RET_MASK = 14'h3C00;
  localparam logic [13:0] LIT_RET_CODE = 14'h3400;
  localparam logic [13:0] ROTL_MASK    = 14'h3F00;
  localparam logic [13:0] ROTL_CODE    = 14'h0D00;

  // ----------------------------------------------------------------
  // cycle counts and reset values
  // ----------------------------------------------------------------
  localparam int          RETURN_CYCLES = 2;
  localparam int          SINGLE_CYCLES = 1;
  localparam logic [7:0]  DATA_RST      = 8'h00;
  localparam logic [6:0]  FADDR_RST     = 7'h00;
  localparam logic [12:0] PC_RST        = 13'h0000;

  // ----------------------------------------------------------------
  // sequencer state and whole-module state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_EXEC  = 2'b00,   // taking a new instruction
    ST_FLUSH = 2'b01    // second cycle of a return
  } seq_state_t;

  typedef struct packed {
    seq_state_t  state;
    logic        ready;
    logic        wWrite;
    logic [7:0]  wData;
    logic        fileWrite;
    logic [6:0]  fileAddr;
    logic [7:0]  fileWdata;
    logic        carryWrite;
    logic        carryData;
    logic        stackPop;
    logic        pcLoad;
    logic [12:0] pcValue;
    logic        pcAdvance;
    logic        intEnableSet;
  } core_t;

endpackage

// File: rotate_left_unit.sv
// rotate-left-through-carry datapath
// assumes operand and carry are valid in the same cycle
`timescale 1ns/1ps
module rotate_left_unit
  import rrx_pkg::*;
#(
  parameter int WIDTH = DATA_W
) (
  // operand
  input  wire logic [WIDTH-1:0] operand,
  input  wire logic             carryIn,
  // result
  output logic      [WIDTH-1:0] result,
  output logic                  carryOut
);

  // old carry enters bit 0, old top bit leaves into carry
  assign result   = {operand[WIDTH-2:0], carryIn};
  assign carryOut = operand[WIDTH-1];

endmodule // rotate_left_unit

// File: return_rotate_instr_exec.sv
// decode and execute of no-op, interrupt return, literal return, rotate left
// assumes the fetch stage presents the word with the addressed file data
// Operation
// RQ1: interrupt return pops the stack and loads its top entry into the pc over two cycles.
// RQ2: interrupt return also sets the global interrupt enable, bit 7 of the control register.
// RQ3: literal return writes its 8-bit immediate into the working register, no flags change.
// RQ4: literal return also pops the stack top into the pc and takes two cycles.
// RQ5: rotate left shifts the file register left through carry, only carry changes, one cycle.
// RQ6: the destination bit sends the rotated value to the working register (0) or file (1).
// RQ7: no-op changes no state and only advances the pc after one cycle.
`timescale 1ns/1ps
module return_rotate_instr_exec
  import rrx_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  // instruction from fetch
  input  wire logic        instrValid,
  input  wire logic [13:0] instrWord,
  // core state read
  input  wire logic [7:0]  fileData,
  input  wire logic        carryIn,
  input  wire logic [12:0] stackTopEntry,
  // fetch handshake
  output logic             ready,
  // working register
  output logic             wWrite,
  output logic [7:0]       wData,
  // file register
  output logic             fileWrite,
  output logic [6:0]       fileAddr,
  output logic [7:0]       fileWdata,
  // carry flag
  output logic             carryWrite,
  output logic             carryData,
  // stack and program counter
  output logic             stackPop,
  output logic             pcLoad,
  output logic [12:0]      pcValue,
  output logic             pcAdvance,
  // interrupt control
  output logic             intEnableSet
);

  // ----------------------------------------------------------------
  // state and decode
  // ----------------------------------------------------------------
  core_t      st;
  core_t      next_st;
  logic       take;
  logic       isNop;
  logic       isIntRet;
  logic       isLitRet;
  logic       isRotLeft;
  logic [7:0] rotResult;
  logic       rotCarry;

  // an instruction is taken only while not in a return's second cycle
  assign take      = instrValid && st.ready;
  assign isNop     = (instrWord & NOP_MASK) == NOP_CODE;
  assign isIntRet  = (instrWord & INT_RET_MASK) == INT_RET_CODE;
  assign isLitRet  = (instrWord & LIT_RET_MASK) == LIT_RET_CODE;
  assign isRotLeft = (instrWord & ROTL_MASK) == ROTL_CODE;

  // rotate datapath
  rotate_left_unit #(
    .WIDTH    (DATA_W)
  ) u_rot (
    .operand  (fileData),
    .carryIn  (carryIn),
    .result   (rotResult),
    .carryOut (rotCarry)
  );

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_st            = st;
    next_st.wWrite     = 1'b0;
    next_st.fileWrite  = 1'b0;
    next_st.carryWrite = 1'b0;
    next_st.stackPop   = 1'b0;
    next_st.pcLoad     = 1'b0;
    next_st.pcAdvance  = 1'b0;
    next_st.intEnableSet = 1'b0;
    case (st.state)
      ST_EXEC: begin
        if (take && isIntRet) begin
          next_st.stackPop = 1'b1;          // RQ1
          next_st.pcLoad   = 1'b1;          // RQ1
          next_st.pcValue  = stackTopEntry; // RQ1
          next_st.intEnableSet = 1'b1;      // RQ2
          next_st.ready    = 1'b0;          // RQ1
          next_st.state    = ST_FLUSH;
        end else if (take && isLitRet) begin
          next_st.wWrite   = 1'b1;          // RQ3
          next_st.wData    = instrWord[7:0]; // RQ3
          next_st.stackPop = 1'b1;          // RQ4
          next_st.pcLoad   = 1'b1;          // RQ4
          next_st.pcValue  = stackTopEntry; // RQ4
          next_st.ready    = 1'b0;          // RQ4
          next_st.state    = ST_FLUSH;
        end else if (take && isRotLeft) begin
          next_st.carryWrite = 1'b1;        // RQ5
          next_st.carryData  = rotCarry;    // RQ5
          next_st.pcAdvance  = 1'b1;        // RQ5
          if (instrWord[DEST_BIT]) begin
            next_st.fileWrite = 1'b1;       // RQ6
            next_st.fileAddr  = instrWord[6:0];
            next_st.fileWdata = rotResult;  // RQ6
          end else begin
            next_st.wWrite = 1'b1;          // RQ6
            next_st.wData  = rotResult;     // RQ6
          end
        end else if (take && isNop) begin
          next_st.pcAdvance = 1'b1;         // RQ7
        end
      end
      ST_FLUSH: begin
        // second cycle of a return: nothing is taken
        next_st.ready = 1'b1;
        next_st.state = ST_EXEC;
      end
      default: begin
        next_st.ready = 1'b1;
        next_st.state = ST_EXEC;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '{state: ST_EXEC, ready: 1'b1, wWrite: 1'b0, wData: DATA_RST,
              fileWrite: 1'b0, fileAddr: FADDR_RST, fileWdata: DATA_RST,
              carryWrite: 1'b0, carryData: 1'b0, stackPop: 1'b0,
              pcLoad: 1'b0, pcValue: PC_RST, pcAdvance: 1'b0, intEnableSet: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state flops
  assign ready      = st.ready;
  assign wWrite     = st.wWrite;
  assign wData      = st.wData;
  assign fileWrite  = st.fileWrite;
  assign fileAddr   = st.fileAddr;
  assign fileWdata  = st.fileWdata;
  assign carryWrite = st.carryWrite;
  assign carryData  = st.carryData;
  assign stackPop   = st.stackPop;
  assign pcLoad     = st.pcLoad;
  assign pcValue    = st.pcValue;
  assign pcAdvance  = st.pcAdvance;
  assign intEnableSet = st.intEnableSet;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_return_two_cycles;
    (stackPop && pcLoad && !ready && !pcAdvance) ##1 (ready && !stackPop && !pcLoad);
  endsequence

  property p_int_ret_pop;
    @(posedge ref_clk) disable iff (!arst_n)
      (take && isIntRet) |=> s_return_two_cycles and (pcValue == $past(stackTopEntry));
  endproperty
  a_int_ret_pop: assert property (p_int_ret_pop) else $error("interrupt return pop wrong"); // RQ1

  property p_int_ret_enable;
    @(posedge ref_clk) disable iff (!arst_n)
      (take && isIntRet) |=> intEnableSet ##1 !intEnableSet;
  endproperty
  a_int_ret_enable: assert property (p_int_ret_enable) else $error("interrupt enable not set once"); // RQ2

  property p_lit_ret_w;
    @(posedge ref_clk) disable iff (!arst_n)
      (take && isLitRet) |=> wWrite && wData == $past(instrWord[7:0]) && !carryWrite
                             && !intEnableSet;
  endproperty
  a_lit_ret_w: assert property (p_lit_ret_w) else $error("literal not loaded to working reg"); // RQ3

  property p_lit_ret_pop;
    @(posedge ref_clk) disable iff (!arst_n)
      (take && isLitRet) |=> s_return_two_cycles and (pcValue == $past(stackTopEntry));
  endproperty
  a_lit_ret_pop: assert property (p_lit_ret_pop) else $error("literal return pop wrong"); // RQ4

  property p_rot_carry;
    @(posedge ref_clk) disable iff (!arst_n)
      (take && isRotLeft) |=> carryWrite && carryData == $past(fileData[MSB_BIT])
                              && !stackPop && ready && pcAdvance;
  endproperty
  a_rot_carry: assert property (p_rot_carry) else $error("rotate carry wrong"); // RQ5

  property p_rot_to_w;
    @(posedge ref_clk) disable iff (!arst_n)
      (take && isRotLeft && !instrWord[DEST_BIT]) |=> wWrite && !fileWrite
        && wData == {$past(fileData[6:0]), $past(carryIn)};
  endproperty
  a_rot_to_w: assert property (p_rot_to_w) else $error("rotate to working reg wrong"); // RQ6

  property p_rot_to_f;
    @(posedge ref_clk) disable iff (!arst_n)
      (take && isRotLeft && instrWord[DEST_BIT]) |=> fileWrite && !wWrite
        && fileAddr == $past(instrWord[6:0])
        && fileWdata == {$past(fileData[6:0]), $past(carryIn)};
  endproperty
  a_rot_to_f: assert property (p_rot_to_f) else $error("rotate to file reg wrong"); // RQ6

  property p_nop_quiet;
    @(posedge ref_clk) disable iff (!arst_n)
      (take && isNop) |=> pcAdvance && ready && !wWrite && !fileWrite && !carryWrite
                          && !stackPop && !pcLoad && !intEnableSet;
  endproperty
  a_nop_quiet: assert property (p_nop_quiet) else $error("no-op changed state"); // RQ7

  property p_flush_ignores;
    @(posedge ref_clk) disable iff (!arst_n)
      !ready |=> !stackPop && !wWrite && !carryWrite && !pcAdvance && !fileWrite;
  endproperty
  a_flush_ignores: assert property (p_flush_ignores) else $error("taken during flush"); // RQ1

endmodule // return_rotate_instr_exec

// File: core_partner_model.sv
// behavioural core: file registers, carry, working register, stack, control reg
// assumes each pulse of the executor lands on the rising edge that ends it
`timescale 1ns/1ps
module core_partner_model (
  // clock and decoded word
  input  wire logic        ref_clk,
  input  wire logic [13:0] instrWord,
  // writes from the executor
  input  wire logic        wWrite,
  input  wire logic [7:0]  wData,
  input  wire logic        fileWrite,
  input  wire logic [6:0]  fileAddr,
  input  wire logic [7:0]  fileWdata,
  input  wire logic        carryWrite,
  input  wire logic        carryData,
  input  wire logic        stackPop,
  input  wire logic        intEnableSet,
  // state read back
  output logic      [7:0]  fileData,
  output logic             carryIn,
  output logic      [12:0] stackTopEntry
);
  localparam int ENABLE_BIT_M = 7;
  logic [7:0]  regs [128];
  logic [12:0] stack [8];
  logic [2:0]  ptr     = 3'h0;
  logic        carry   = 1'b0;
  logic [7:0]  wReg    = 8'h00;
  logic [7:0]  intCtrl = 8'h00;
  // forwarding, so a back-to-back word sees the write of the one before
  assign carryIn       = carryWrite ? carryData : carry;
  assign fileData      = (fileWrite && fileAddr == instrWord[6:0]) ? fileWdata
                                                                   : regs[instrWord[6:0]];
  assign stackTopEntry = stack[ptr];
  // fill memories with a plain pattern
  initial begin
    for (int i = 0; i < 128; i++) regs[i] = 8'(i * 37 + 5);
    for (int i = 0; i < 8; i++) stack[i] = 13'(i * 333 + 17);
  end
  // apply executor writes
  always @(posedge ref_clk) begin
    if (carryWrite) carry <= carryData;
    if (fileWrite) regs[fileAddr] <= fileWdata;
    if (wWrite) wReg <= wData;
    if (stackPop) ptr <= ptr - 3'h1;
    if (intEnableSet) intCtrl[ENABLE_BIT_M] <= 1'b1;
  end
endmodule // core_partner_model

// File: return_rotate_instr_exec_test.sv
// self-checking bench of the no-op, return and rotate executor
// assumes core_partner_model stands in for register file, carry and stack
`timescale 1ns/1ps
module return_rotate_instr_exec_test;
  import rrx_pkg::*;
  logic        ref_clk    = 1'b0;
  logic        arst_n     = 1'b0;
  logic        instrValid = 1'b0;
  logic [13:0] instrWord  = 14'h0000;
  logic [7:0]  fileData, wData, fileWdata, fd, e;
  logic        carryIn, ready, wWrite, fileWrite, carryWrite, carryData, cy;
  logic        stackPop, pcLoad, pcAdvance, intEnableSet;
  logic [6:0]  fileAddr;
  logic [12:0] stackTopEntry, pcValue, top;
  logic [31:0] r;
  int          error_cnt    = 0;
  int          total_checks = 0;
  wire  [7:0]  flags = {ready, wWrite, fileWrite, carryWrite,
                        stackPop, pcLoad, pcAdvance, intEnableSet};

  always #50 ref_clk = ~ref_clk;
  return_rotate_instr_exec dut (
    .ref_clk       (ref_clk),
    .arst_n        (arst_n),
    .instrValid    (instrValid),
    .instrWord     (instrWord),
    .fileData      (fileData),
    .carryIn       (carryIn),
    .stackTopEntry (stackTopEntry),
    .ready         (ready),
    .wWrite        (wWrite),
    .wData         (wData),
    .fileWrite     (fileWrite),
    .fileAddr      (fileAddr),
    .fileWdata     (fileWdata),
    .carryWrite    (carryWrite),
    .carryData     (carryData),
    .stackPop      (stackPop),
    .pcLoad        (pcLoad),
    .pcValue       (pcValue),
    .pcAdvance     (pcAdvance),
    .intEnableSet  (intEnableSet)
  );
  core_partner_model core (
    .ref_clk       (ref_clk),
    .instrWord     (instrWord),
    .wWrite        (wWrite),
    .wData         (wData),
    .fileWrite     (fileWrite),
    .fileAddr      (fileAddr),
    .fileWdata     (fileWdata),
    .carryWrite    (carryWrite),
    .carryData     (carryData),
    .stackPop      (stackPop),
    .intEnableSet  (intEnableSet),
    .fileData      (fileData),
    .carryIn       (carryIn),
    .stackTopEntry (stackTopEntry)
  );

  // ----------------------------------------------------------------
  // compare, expectation and drive helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // pulse pattern one cycle after a take
  function automatic logic [7:0] exp_flags(input logic [13:0] w);
    if (w == INT_RET_CODE) return 8'h0D;
    if ((w & LIT_RET_MASK) == LIT_RET_CODE) return 8'h4C;
    if ((w & ROTL_MASK) == ROTL_CODE) return w[DEST_BIT] ? 8'hB2 : 8'hD2;
    return 8'h82;
  endfunction
  // offer a word at the falling edge, check its answer cycle
  task automatic run(input logic [13:0] w);
    instrValid = 1'b1;
    instrWord = w;
    e = exp_flags(w);
    #1;
    fd = fileData;
    cy = carryIn;
    top = stackTopEntry;
    @(negedge ref_clk);
    check(16'(flags), 16'(e));
    if (e == 8'h4C) check(16'(wData), 16'(w[7:0]));
    if (e[3]) check(16'(pcValue), 16'(top));
    if (e[5]) check({1'b0, fileAddr, fileWdata}, {1'b0, w[6:0], fd[6:0], cy});
    if (e[4]) check({carryData, e[6] ? wData : fileWdata}, {fd[7], fd[6:0], cy});
    if (!e[7]) begin
      instrWord = ROTL_CODE;
      @(negedge ref_clk);
      check(16'(flags), 16'h0080);
    end
  endtask
  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(45));
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    check(16'(flags), 16'h0080);
    arst_n = 1'b1;
    for (int x = 0; x < 4; x++) run(NOP_CODE | 14'(x << 5));
    run(INT_RET_CODE);
    check(16'(core.intCtrl[ENABLE_BIT]), 16'h0001);
    run(LIT_RET_CODE | 14'h0000);
    run(LIT_RET_CODE | 14'h03FF);
    run(ROTL_CODE | 14'h00FF);
    run(ROTL_CODE | 14'h00FF);
    for (int i = 0; i < 80; i++) begin
      r = $urandom;
      case (r[9:8])
        2'd0: run(NOP_CODE | {7'h00, r[1:0], 5'h00});
        2'd1: run(INT_RET_CODE);
        2'd2: run(LIT_RET_CODE | {4'h0, r[11:10], r[7:0]});
        default: run(ROTL_CODE | {6'h00, r[7:0]});
      endcase
    end
    instrValid = 1'b0;
    @(negedge ref_clk);
    check(16'(flags), 16'h0080);
    report_and_stop();
  end
  // watchdog
  initial begin
    #1ms;
    error_cnt++;
    report_and_stop();
  end
endmodule // return_rotate_instr_exec_test
